// [rtl/adc_seq_pkg.sv]
package adc_seq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int INIT_TIME_US = 1000;
  localparam int WAKE_TIME_US = 1000;
  localparam int RAMP_TIME_US = 5000;
  localparam int INIT_CYC = INIT_TIME_US * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_TIME_US * CLK_MHZ;
  localparam int GAIN_W = 9;
  localparam logic [GAIN_W-1:0] GAIN_FULL = 9'h100;
  localparam int GAIN_STEPS = 256;
  localparam int RAMP_STEP_CYC = RAMP_TIME_US * CLK_MHZ / GAIN_STEPS;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h04;
  localparam logic [7:0] ADDR_SLOT_EN = 8'h08;
  localparam logic [7:0] ADDR_BLOCK_PWR = 8'h0c;
  localparam logic [7:0] ADDR_PWR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_ASI_CFG = 8'h1c;

  // ****************************************
  // Fields
  // ****************************************
  localparam int SLEEP_BIT = 0;
  localparam int PWR_ADC_BIT = 0;
  localparam int PWR_BIAS_BIT = 1;
  localparam int PWR_PLL_BIT = 2;
  localparam int STAT_SLEEP_BIT = 7;
  localparam int STAT_AWAKE_BIT = 6;
  localparam int STAT_RAMP_BIT = 5;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_SLEEP_BIT = 1;
  localparam int IRQ_FRAME_BIT = 2;
  localparam int CFG_WL32_BIT = 0;
  localparam int NUM_CH = 2;
  localparam int NUM_IRQ = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic SLEEP_RST = 1'b1;
  localparam logic [NUM_CH-1:0] CHAN_EN_RST = 2'h0;
  localparam logic [NUM_CH-1:0] SLOT_EN_RST = 2'h0;
  localparam logic [2:0] BLOCK_PWR_RST = 3'h0;
  localparam logic [NUM_IRQ-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic CFG_WL32_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_SLEEP,
    ST_WAKE,
    ST_ACTIVE,
    ST_RAMP,
    ST_OFF
  } seq_state_t;

endpackage

// [rtl/bit_sync.sv]
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // First stage is read only by the second
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [rtl/tdm_slot_tx.sv]
`timescale 1ns/100ps
module tdm_slot_tx #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Frame timing from the bit clock edges
  input wire logic frame_start,
  input wire logic shift,
  // Frame content
  input wire logic enable,
  input wire logic wl32,
  input wire logic [1:0] slot_en,
  input wire logic [W-1:0] word0,
  input wire logic [W-1:0] word1,
  // Serial data
  output logic sd_q
);

  logic [2*W-1:0] sh_q;
  logic [2*W-1:0] sh_d;
  logic [2*W-1:0] pack;
  logic [W-1:0] w0;
  logic [W-1:0] w1;
  logic sd_d;

  always_comb begin
    w0 = slot_en[0] ? word0 : '0;
    w1 = slot_en[1] ? word1 : '0;
    // Short words pack back to back, the tail of the frame reads zero
    if (wl32) begin
      pack = {w0, w1};
    end else begin
      pack = {w0[W-1:W/2], w1[W-1:W/2], {W{1'b0}}};
    end
    sh_d = sh_q;
    sd_d = sd_q;
    if (frame_start) begin
      sh_d = enable ? pack : '0;
    end else if (shift) begin
      sd_d = sh_q[2*W-1];
      sh_d = {sh_q[2*W-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sh_q <= '0;
      sd_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      sd_q <= sd_d;
    end
  end

endmodule

// [rtl/adc_power_seq.sv]
// Contract
// - Enabled, powered, clocked device sends samples on the TDM bus.
// - On sleep, ramp volume down then power down, within 6 ms.
// - Status bit 7 reports sleep; host stops clocks only then.
// - All register values are kept through sleep.
// - Serial interface supports output sample rates up to 768 kHz; here with 16-bit words only, 32-bit frames need a bit clock over mclk/4.
// - Control registers are written through the control port.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module adc_power_seq
  import adc_seq_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int RAMP_STEP_CYCLES = RAMP_STEP_CYC,
  parameter int SAMPLE_W = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Converter samples, same clock
  input wire logic [SAMPLE_W-1:0] sample_ch1,
  input wire logic [SAMPLE_W-1:0] sample_ch2,
  // Block power enables
  output logic adc_power_en,
  output logic microphone_bias_supply_en,
  output logic pll_en,
  // Audio serial link
  input wire logic frame_sync,
  input wire logic bit_clock,
  output logic sdout
);

  // ****************************************
  // Declarations
  // ****************************************
  seq_state_t state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic [GAIN_W-1:0] gain_q, gain_d;
  logic sleep_q, sleep_d;
  logic [NUM_CH-1:0] chan_en_q, chan_en_d;
  logic [NUM_CH-1:0] slot_en_q, slot_en_d;
  logic [2:0] blk_pwr_q, blk_pwr_d;
  logic wl32_q, wl32_d;
  logic [NUM_IRQ-1:0] irq_stat_q, irq_stat_d;
  logic [NUM_IRQ-1:0] irq_mask_q, irq_mask_d;
  logic [NUM_IRQ-1:0] irq_evt;
  logic [31:0] rdata_d;
  logic wait_d;
  logic irq_d;
  logic [2:0] pwr_out_q, pwr_out_d;
  logic wr_take, rd_take, lo_lane;
  logic wake_done, sleep_done;
  logic [1:0] link_s;
  logic fs_s, bc_s;
  logic bc_prev_q, fs_rise_q;
  logic bc_rise, bc_fall, frame_start;
  logic stream_on;
  logic [SAMPLE_W+GAIN_W:0] prod1, prod2;
  logic [SAMPLE_W-1:0] word1, word2;
  logic [7:0] pwr_status;

  // ****************************************
  // Register bus
  // ****************************************
  // One wait state: waitrequest drops for one cycle after a request,
  // and stays high through power-up initialisation.
  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && !avs_waitrequest;
  assign lo_lane = avs_byteenable[0];

  always_comb begin
    pwr_status = 8'h00;
    pwr_status[STAT_SLEEP_BIT] = (state_q == ST_SLEEP);
    pwr_status[STAT_AWAKE_BIT] = (state_q == ST_ACTIVE);
    pwr_status[STAT_RAMP_BIT] = (state_q == ST_RAMP);
    pwr_status[2:0] = pwr_out_q;
  end

  always_comb begin
    wait_d = 1'b1;
    if (state_q != ST_INIT && (avs_read || avs_write) && avs_waitrequest) begin
      wait_d = 1'b0;
    end
    rdata_d = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      rdata_d = 32'h0000_0000;
      if (avs_address == ADDR_SLEEP_CTRL) begin
        rdata_d[SLEEP_BIT] = sleep_q;
      end else if (avs_address == ADDR_CHAN_EN) begin
        rdata_d[NUM_CH-1:0] = chan_en_q;
      end else if (avs_address == ADDR_SLOT_EN) begin
        rdata_d[NUM_CH-1:0] = slot_en_q;
      end else if (avs_address == ADDR_BLOCK_PWR) begin
        rdata_d[2:0] = blk_pwr_q;
      end else if (avs_address == ADDR_PWR_STATUS) begin
        rdata_d[7:0] = pwr_status;
      end else if (avs_address == ADDR_IRQ_STATUS) begin
        rdata_d[NUM_IRQ-1:0] = irq_stat_q;
      end else if (avs_address == ADDR_IRQ_MASK) begin
        rdata_d[NUM_IRQ-1:0] = irq_mask_q;
      end else if (avs_address == ADDR_ASI_CFG) begin
        rdata_d[CFG_WL32_BIT] = wl32_q;
      end
    end
  end

  // Writes land regardless of power state; nothing clears them on sleep
  always_comb begin
    sleep_d = sleep_q;
    chan_en_d = chan_en_q;
    slot_en_d = slot_en_q;
    blk_pwr_d = blk_pwr_q;
    wl32_d = wl32_q;
    irq_mask_d = irq_mask_q;
    if (wr_take && lo_lane) begin
      if (avs_address == ADDR_SLEEP_CTRL) begin
        sleep_d = avs_writedata[SLEEP_BIT];
      end else if (avs_address == ADDR_CHAN_EN) begin
        chan_en_d = avs_writedata[NUM_CH-1:0];
      end else if (avs_address == ADDR_SLOT_EN) begin
        slot_en_d = avs_writedata[NUM_CH-1:0];
      end else if (avs_address == ADDR_BLOCK_PWR) begin
        blk_pwr_d = avs_writedata[2:0];
      end else if (avs_address == ADDR_IRQ_MASK) begin
        irq_mask_d = avs_writedata[NUM_IRQ-1:0];
      end else if (avs_address == ADDR_ASI_CFG) begin
        wl32_d = avs_writedata[CFG_WL32_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      sleep_q <= SLEEP_RST;
      chan_en_q <= CHAN_EN_RST;
      slot_en_q <= SLOT_EN_RST;
      blk_pwr_q <= BLOCK_PWR_RST;
      wl32_q <= CFG_WL32_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else begin
      avs_waitrequest <= wait_d;
      avs_readdata <= rdata_d;
      sleep_q <= sleep_d;
      chan_en_q <= chan_en_d;
      slot_en_q <= slot_en_d;
      blk_pwr_q <= blk_pwr_d;
      wl32_q <= wl32_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ****************************************
  // Power sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    timer_d = timer_q + 32'd1;
    gain_d = gain_q;
    wake_done = 1'b0;
    sleep_done = 1'b0;
    case (state_q)
      ST_INIT: begin
        if (timer_q >= 32'(INIT_CYCLES - 1)) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        timer_d = 32'd0;
        if (!sleep_q) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (sleep_q) begin
          state_d = ST_SLEEP;
        end else if (timer_q >= 32'(WAKE_CYCLES - 1)) begin
          state_d = ST_ACTIVE;
          gain_d = GAIN_FULL;
          wake_done = 1'b1;
        end
      end
      ST_ACTIVE: begin
        timer_d = 32'd0;
        if (sleep_q) begin
          state_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        // Timer-driven so the ramp finishes even if the link stops early
        if (timer_q >= 32'(RAMP_STEP_CYCLES - 1)) begin
          timer_d = 32'd0;
          if (gain_q == '0) begin
            state_d = ST_OFF;
          end else begin
            gain_d = gain_q - 9'd1;
          end
        end
      end
      ST_OFF: begin
        state_d = ST_SLEEP;
        sleep_done = 1'b1;
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  // Blocks follow the power register only while active or ramping down
  always_comb begin
    pwr_out_d = 3'h0;
    if (state_q == ST_ACTIVE || state_q == ST_RAMP) begin
      pwr_out_d = blk_pwr_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_INIT;
      timer_q <= 32'd0;
      gain_q <= GAIN_FULL;
      pwr_out_q <= 3'h0;
      adc_power_en <= 1'b0;
      microphone_bias_supply_en <= 1'b0;
      pll_en <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      gain_q <= gain_d;
      pwr_out_q <= pwr_out_d;
      adc_power_en <= pwr_out_d[PWR_ADC_BIT];
      microphone_bias_supply_en <= pwr_out_d[PWR_BIAS_BIT];
      pll_en <= pwr_out_d[PWR_PLL_BIT];
    end
  end

  // ****************************************
  // Audio serial link
  // ****************************************
  bit_sync #(
    .W(2)
  ) u_link_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({frame_sync, bit_clock}),
    .sync_out(link_s)
  );

  assign fs_s = link_s[1];
  assign bc_s = link_s[0];
  // Edges seen at mclk rate; limits bit clock to well under mclk/4
  assign bc_rise = bc_s && !bc_prev_q;
  assign bc_fall = !bc_s && bc_prev_q;
  assign frame_start = bc_rise && fs_s && !fs_rise_q;
  assign stream_on = pwr_out_q[PWR_ADC_BIT] && pwr_out_q[PWR_PLL_BIT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bc_prev_q <= 1'b0;
      fs_rise_q <= 1'b0;
    end else begin
      bc_prev_q <= bc_s;
      fs_rise_q <= bc_rise ? fs_s : fs_rise_q;
    end
  end

  // Volume applied as sample * gain / 256
  assign prod1 = $signed({{(GAIN_W+1){sample_ch1[SAMPLE_W-1]}}, sample_ch1})
    * $signed({{(SAMPLE_W+1){1'b0}}, gain_q});
  assign prod2 = $signed({{(GAIN_W+1){sample_ch2[SAMPLE_W-1]}}, sample_ch2})
    * $signed({{(SAMPLE_W+1){1'b0}}, gain_q});
  assign word1 = prod1[SAMPLE_W+7:8];
  assign word2 = prod2[SAMPLE_W+7:8];

  // 16-bit words fit a 768 kHz frame at the fastest bit clock
  tdm_slot_tx #(
    .W(SAMPLE_W)
  ) u_tx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .frame_start(frame_start),
    .shift(bc_fall),
    .enable(stream_on),
    .wl32(wl32_q),
    .slot_en(chan_en_q & slot_en_q),
    .word0(word1),
    .word1(word2),
    .sd_q(sdout)
  );

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_evt[IRQ_WAKE_BIT] = wake_done;
  assign irq_evt[IRQ_SLEEP_BIT] = sleep_done;
  assign irq_evt[IRQ_FRAME_BIT] = frame_start && stream_on;

  // New event beats a write-one-to-clear in the same cycle
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_take && lo_lane && avs_address == ADDR_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~avs_writedata[NUM_IRQ-1:0];
    end
    irq_stat_d = irq_stat_d | irq_evt;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq <= irq_d;
    end
  end

endmodule

// [testbench/adc_power_seq_monitor.sv]
`timescale 1ns/100ps
module adc_power_seq_monitor
  import adc_seq_pkg::*;
#(
  parameter int RAMP_STEP_CYCLES = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt, power, link
  input wire logic irq,
  input wire logic adc_power_en,
  input wire logic microphone_bias_supply_en,
  input wire logic pll_en,
  input wire logic sdout
);
  // ****************
  // Helpers
  // ****************
  localparam int RAMP_LIM = 256 * RAMP_STEP_CYCLES + 32;
  // Over one frame: a frame under way may finish
  localparam int OFF_LIM = 1000;
  logic sleep_req;
  logic all_off;
  logic ramp_q;
  logic [15:0] ramp_cnt_q;
  logic [10:0] off_cnt_q;
  assign sleep_req = avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address == ADDR_SLEEP_CTRL && avs_writedata[SLEEP_BIT];
  assign all_off = !adc_power_en && !microphone_bias_supply_en && !pll_en;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ramp_q <= 1'b0;
      ramp_cnt_q <= 16'h0;
      off_cnt_q <= 11'h0;
    end else begin
      ramp_q <= (sleep_req && adc_power_en) || (ramp_q && !all_off);
      ramp_cnt_q <= ramp_q ? ramp_cnt_q + 16'h1 : 16'h0;
      if (adc_power_en)
        off_cnt_q <= 11'h0;
      else if (off_cnt_q != OFF_LIM)
        off_cnt_q <= off_cnt_q + 11'h1;
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
  wait_cause_a: assert property (
    !avs_waitrequest |-> avs_read || avs_write)
    else $error("answer without request");
  init_hold_a: assert property ($fell(sys_rst) |->
    (avs_waitrequest && !irq && !adc_power_en) [*8])
    else $error("bus or power active during init");
  power_hold_a: assert property (
    sleep_req && adc_power_en |=> adc_power_en [*8])
    else $error("power dropped before ramp");
  power_off_a: assert property (ramp_cnt_q <= RAMP_LIM)
    else $error("blocks not powered down after ramp");
  sleep_stat_a: assert property (
    !avs_waitrequest && avs_read && avs_address == ADDR_PWR_STATUS
    && adc_power_en |-> !avs_readdata[STAT_SLEEP_BIT])
    else $error("sleep reported while powered");
  quiet_out_a: assert property (off_cnt_q == OFF_LIM |-> !sdout)
    else $error("serial data while converter off");
endmodule

// [testbench/tdm_host_model.sv]
`timescale 1ns/100ps
module tdm_host_model (
  // Link to the device
  input wire logic sdout,
  output logic frame_sync,
  output logic bit_clock
);
  initial begin
    frame_sync = 1'b0;
    bit_clock = 1'b0;
  end

  // Bit clock stands low between frames, phase free of mclk
  task automatic frame(output logic [63:0] w);
    w = 64'h0;
    #43 bit_clock = 1'b1;
    #40 bit_clock = 1'b0;
    frame_sync = 1'b1;
    #40 bit_clock = 1'b1;
    #40 bit_clock = 1'b0;
    frame_sync = 1'b0;
    // Sample late in the bit: data follows each fall
    for (int i = 0; i < 64; i++) begin
      #38 w = {w[62:0], sdout};
      #2 bit_clock = 1'b1;
      #40 bit_clock = 1'b0;
    end
  endtask
endmodule

// [testbench/test_adc_power_seq.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module test_adc_power_seq;
  import adc_seq_pkg::*;
  localparam int RSTEP = 4;
  logic mclk;
  logic sys_rst;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq;
  logic [31:0] avs_writedata, avs_readdata, rd, sample_ch1, sample_ch2;
  logic [3:0] avs_byteenable;
  logic adc_power_en, microphone_bias_supply_en, pll_en;
  logic frame_sync, bit_clock, sdout;
  logic [63:0] w;
  int n_fail, tests_run, cyc, t0;
  logic [7:0] ra [9] = '{ADDR_SLEEP_CTRL, ADDR_CHAN_EN, ADDR_SLOT_EN,
    ADDR_BLOCK_PWR, ADDR_PWR_STATUS, ADDR_IRQ_STATUS, ADDR_IRQ_MASK,
    ADDR_ASI_CFG, 8'h20};
  logic [31:0] rv [9] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h80, 32'h0,
    32'h0, 32'h1, 32'h0};

  adc_power_seq #(
    .INIT_CYCLES(50),
    .WAKE_CYCLES(50),
    .RAMP_STEP_CYCLES(RSTEP),
    .SAMPLE_W(32)
  ) i_dut (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .irq, .sample_ch1, .sample_ch2, .adc_power_en,
    .microphone_bias_supply_en, .pll_en, .frame_sync, .bit_clock, .sdout);

  tdm_host_model i_host (.sdout, .frame_sync, .bit_clock);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ****************
  // Bus tasks
  // ****************
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(rd, e)
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_PWR_STATUS, 32'h0, 4'hf);
      n++;
    end while (rd[b] !== 1'b1 && n < 600);
    `CHK(rd[b], 1'b1)
  endtask
  task automatic frame_chk(input logic [63:0] e);
    i_host.frame(w);
    @(posedge mclk);
    `CHK(w, e)
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, run needs under 10000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    sys_rst = 1'b1;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    sample_ch1 = 32'h1234_5678;
    sample_ch2 = 32'ha5c3_0f96;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    wreg(ADDR_PWR_STATUS, 32'h0);
    wreg(8'h20, 32'hff);
    bus(1'b1, ADDR_CHAN_EN, 32'h3, 4'he);
    rchk(ADDR_PWR_STATUS, 32'h80);
    rchk(ADDR_CHAN_EN, 32'h0);
    repeat (2) frame_chk(64'h0);
    $display("test reset done");
    wreg(ADDR_SLEEP_CTRL, 32'h0);
    poll(STAT_AWAKE_BIT);
    rchk(ADDR_IRQ_STATUS, 32'h1);
    `CHK(irq, 1'b0)
    wreg(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1)
    wreg(ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    $display("test wake done");
    wreg(ADDR_ASI_CFG, 32'h1);
    wreg(ADDR_CHAN_EN, 32'h3);
    wreg(ADDR_SLOT_EN, 32'h1);
    wreg(ADDR_BLOCK_PWR, 32'h7);
    repeat (2) @(posedge mclk);
    `CHK({adc_power_en, microphone_bias_supply_en, pll_en}, 3'h7)
    rchk(ADDR_PWR_STATUS, 32'h47);
    frame_chk({sample_ch1, 32'h0});
    wreg(ADDR_SLOT_EN, 32'h3);
    frame_chk({sample_ch1, sample_ch2});
    rchk(ADDR_IRQ_STATUS, 32'h4);
    // Short words: both slots in the first half, tail reads zero
    wreg(ADDR_ASI_CFG, 32'h0);
    frame_chk({sample_ch1[31:16], sample_ch2[31:16], 32'h0});
    wreg(ADDR_ASI_CFG, 32'h1);
    $display("test stream done");
    wreg(ADDR_IRQ_STATUS, 32'h7);
    wreg(ADDR_IRQ_MASK, 32'h2);
    t0 = cyc;
    wreg(ADDR_SLEEP_CTRL, 32'h1);
    poll(STAT_SLEEP_BIT);
    `CHK(cyc - t0 >= 256 * RSTEP, 1'b1)
    repeat (2) @(posedge mclk);
    `CHK({irq, adc_power_en, microphone_bias_supply_en, pll_en}, 4'h8)
    rchk(ADDR_IRQ_STATUS, 32'h2);
    rchk(ADDR_CHAN_EN, 32'h3);
    rchk(ADDR_SLOT_EN, 32'h3);
    rchk(ADDR_BLOCK_PWR, 32'h7);
    rchk(ADDR_PWR_STATUS, 32'h80);
    wreg(ADDR_IRQ_STATUS, 32'h2);
    $display("test sleep done");
    wreg(ADDR_SLEEP_CTRL, 32'h0);
    poll(STAT_AWAKE_BIT);
    frame_chk({sample_ch1, sample_ch2});
    $display("test rewake done");
    end_sim();
  end
endmodule

bind adc_power_seq adc_power_seq_monitor #(
  .RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)
) i_mon (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
  .adc_power_en, .microphone_bias_supply_en, .pll_en, .sdout);
